// ---- rtl/ditd_pkg.sv ----
package ditd_pkg;

  // ************************************************************
  // widths and counts
  // ************************************************************
  localparam int unsigned NUM_TERMS  = 8;
  localparam int unsigned CODE_W     = 6;
  localparam int unsigned FREQ_W     = 16;
  localparam int unsigned ANA_W      = 12;
  localparam int unsigned SEL_W      = 4;
  localparam int unsigned PAIR_W     = 2;
  localparam int unsigned AUX_W      = 10;
  localparam int unsigned MAX_CODE   = 32;

  // ************************************************************
  // terminal function codes
  // ************************************************************
  localparam logic [5:0] FN_NONE     = 6'h00;
  localparam logic [5:0] FN_JOG      = 6'h01;
  localparam logic [5:0] FN_JOG_FWD  = 6'h02;
  localparam logic [5:0] FN_JOG_REV  = 6'h03;
  localparam logic [5:0] FN_TOGGLE   = 6'h04;
  localparam logic [5:0] FN_RUN      = 6'h05;
  localparam logic [5:0] FN_FWD      = 6'h06;
  localparam logic [5:0] FN_REV      = 6'h07;
  localparam logic [5:0] FN_STOP     = 6'h08;
  localparam logic [5:0] FN_SPD1     = 6'h09;
  localparam logic [5:0] FN_RAMP1    = 6'h0D;
  localparam logic [5:0] FN_UP       = 6'h0F;
  localparam logic [5:0] FN_DOWN     = 6'h10;
  localparam logic [5:0] FN_COAST    = 6'h11;
  localparam logic [5:0] FN_FAULTRST = 6'h12;
  localparam logic [5:0] FN_AUX_LO   = 6'h13;
  localparam logic [5:0] FN_AUX_HI   = 6'h1A;

  // ************************************************************
  // defaults and timing
  // ************************************************************
  localparam logic [5:0]  FWD_FN_DEFAULT = FN_FWD;
  localparam logic [5:0]  REV_FN_DEFAULT = FN_REV;
  localparam logic [15:0] JOG_FREQ_DEFAULT = 16'h01F4; // 5.00 Hz in 0.01 Hz
  localparam int unsigned UPDN_STEP_US = 100;          // one 0.01 Hz step per interval
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned UPDN_STEP_CYC = UPDN_STEP_US * CLK_MHZ;
  localparam logic [15:0] FREQ_ZERO = 16'h0000;

  // ************************************************************
  // drive run state
  // ************************************************************
  typedef enum logic [1:0] {
    DITD_STOPPED,
    DITD_RUNNING,
    DITD_JOGGING
  } ditd_mode_t;

endpackage

// ---- rtl/ditd_analog_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// analog curve request and answer
// ************************************************************
interface ditd_analog_if;
  import ditd_pkg::*;
  logic [ANA_W-1:0]  level;
  logic [ANA_W-1:0]  in_min;
  logic [ANA_W-1:0]  in_max;
  logic [FREQ_W-1:0] lo_freq;
  logic              lo_dir;
  logic [FREQ_W-1:0] hi_freq;
  logic              hi_dir;
  logic              rev_opt;
  logic              valid;
  logic [FREQ_W-1:0] freq;
  logic              dir;
  modport mapper (input level, in_min, in_max, lo_freq, lo_dir, hi_freq, hi_dir, rev_opt,
                  output valid, freq, dir);
  modport user (output level, in_min, in_max, lo_freq, lo_dir, hi_freq, hi_dir, rev_opt,
                input valid, freq, dir);
endinterface
`default_nettype wire

// ---- rtl/ditd_analog_map.sv ----
`timescale 1ns/1ps
`default_nettype none
module ditd_analog_map
  import ditd_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  ditd_analog_if.mapper a
);

  logic              valid_d, valid_q;
  logic [FREQ_W-1:0] freq_d,  freq_q;
  logic              dir_d,   dir_q;

  // signed point on the curve, negative side means reverse
  function automatic logic signed [FREQ_W+1:0] sgn(input logic [FREQ_W-1:0] f, input logic d);
    sgn = d ? -$signed({2'b00, f}) : $signed({2'b00, f});
  endfunction

  // ************************************************************
  // curve evaluation
  // ************************************************************
  always_comb begin
    logic [ANA_W-1:0]           lvl;
    logic [ANA_W-1:0]           span;
    logic signed [FREQ_W+1:0]   lo_s;
    logic signed [FREQ_W+1:0]   hi_s;
    logic signed [FREQ_W+ANA_W+3:0] prod;
    logic signed [FREQ_W+1:0]   res;
    lvl  = (a.level > a.in_max) ? a.in_max : a.level;
    span = a.in_max - a.in_min;
    lo_s = sgn(a.lo_freq, a.lo_dir);
    hi_s = sgn(a.hi_freq, a.hi_dir);
    prod = '0;
    if (span != '0)
      prod = ((hi_s - lo_s) * $signed({1'b0, lvl - a.in_min})) / $signed({1'b0, span});
    res  = lo_s + prod[FREQ_W+1:0];
    valid_d = (a.level >= a.in_min);
    dir_d   = res[FREQ_W+1];
    freq_d  = res[FREQ_W+1] ? FREQ_W'(-res) : res[FREQ_W-1:0];
    if (res[FREQ_W+1] && !a.rev_opt) begin
      freq_d = FREQ_ZERO;
      dir_d  = 1'b0;
    end
    if (!valid_d) begin
      freq_d = freq_q;
      dir_d  = dir_q;
    end
  end

  // registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      freq_q  <= FREQ_ZERO;
      dir_q   <= 1'b0;
    end else begin
      valid_q <= valid_d;
      freq_q  <= freq_d;
      dir_q   <= dir_d;
    end
  end

  assign a.valid = valid_q;
  assign a.freq  = freq_q;
  assign a.dir   = dir_q;

  chk_below_min_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !valid_d |=> (freq_q == $past(freq_q))) else $error("invalid analog changed output");
  chk_no_reverse: assert property (@(posedge clock) disable iff (!rst_n)
    !a.rev_opt && valid_d |=> !dir_q) else $error("reverse under option 0");

endmodule
`default_nettype wire

// ---- rtl/ditd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ditd_top
  import ditd_pkg::*;
#(
  parameter int unsigned UPDN_STEP = UPDN_STEP_CYC
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic [NUM_TERMS-1:0]        terminal_in,
  input  wire logic [NUM_TERMS*CODE_W-1:0] terminal_function,
  input  wire logic [ANA_W-1:0]            analog_voltage_input,
  input  wire logic [ANA_W-1:0]            voltage_input_minimum,
  input  wire logic [ANA_W-1:0]            voltage_input_maximum,
  input  wire logic                        use_current_input,
  input  wire logic [ANA_W-1:0]            analog_current_input,
  input  wire logic [ANA_W-1:0]            current_input_minimum,
  input  wire logic [ANA_W-1:0]            current_input_maximum,
  input  wire logic [FREQ_W-1:0]           low_end_frequency,
  input  wire logic                        low_end_direction,
  input  wire logic [FREQ_W-1:0]           high_end_frequency,
  input  wire logic                        high_end_direction,
  input  wire logic                        analog_reverse_option,
  input  wire logic                        use_analog_reference,
  input  wire logic [FREQ_W-1:0]           primary_frequency_setting,
  input  wire logic [FREQ_W-1:0]           jog_frequency,
  input  wire logic [FREQ_W-1:0]           max_frequency,
  input  wire logic [FREQ_W-1:0]           min_frequency,
  input  wire logic [15*FREQ_W-1:0]        preset_speeds,
  output logic                             run_out,
  output logic                             reverse_out,
  output logic                             jog_out,
  output logic [FREQ_W-1:0]                target_frequency,
  output logic [PAIR_W-1:0]                ramp_pair,
  output logic [SEL_W-1:0]                 speed_index,
  output logic                             coast_stop,
  output logic                             fault_reset,
  output logic [AUX_W-1:0]                 aux_enables,
  output logic                             analog_valid
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (UPDN_STEP < 1) begin : g_bad_step
    $error("up/down step interval must be at least one cycle");
  end

  // ************************************************************
  // terminal decoding
  // ************************************************************
  // level of the function code over all terminals carrying it
  function automatic logic fn_on(input logic [NUM_TERMS*CODE_W-1:0] fns,
                                 input logic [NUM_TERMS-1:0] lv, input logic [5:0] code);
    fn_on = 1'b0;
    for (int i = 0; i < NUM_TERMS; i++)
      if (fns[i*CODE_W +: CODE_W] == code && code != FN_NONE && code <= 6'(MAX_CODE))
        fn_on = fn_on | lv[i];
  endfunction

  logic              jog_any;
  logic              jog_f;
  logic              jog_r;
  logic              tog;
  logic              run_cmd;
  logic              forward_terminal;
  logic              reverse_terminal;
  logic              stp;
  logic              up;
  logic              dn;
  logic [SEL_W-1:0]  sel;
  logic [PAIR_W-1:0] rsel;
  logic [AUX_W-1:0]  aux;

  always_comb begin
    jog_any = fn_on(terminal_function, terminal_in, FN_JOG);
    jog_f   = fn_on(terminal_function, terminal_in, FN_JOG_FWD);
    jog_r   = fn_on(terminal_function, terminal_in, FN_JOG_REV);
    tog     = fn_on(terminal_function, terminal_in, FN_TOGGLE);
    run_cmd = fn_on(terminal_function, terminal_in, FN_RUN);
    forward_terminal     = fn_on(terminal_function, terminal_in, FN_FWD);
    reverse_terminal     = fn_on(terminal_function, terminal_in, FN_REV);
    stp     = fn_on(terminal_function, terminal_in, FN_STOP);
    up      = fn_on(terminal_function, terminal_in, FN_UP);
    dn      = fn_on(terminal_function, terminal_in, FN_DOWN);
    for (int k = 0; k < SEL_W; k++)
      sel[k] = fn_on(terminal_function, terminal_in, 6'(FN_SPD1 + 6'(k)));
    for (int k = 0; k < PAIR_W; k++)
      rsel[k] = fn_on(terminal_function, terminal_in, 6'(FN_RAMP1 + 6'(k)));
    for (int k = 0; k < AUX_W - 2; k++)
      aux[k] = fn_on(terminal_function, terminal_in, 6'(FN_AUX_LO + 6'(k)));
    aux[AUX_W-2] = 1'b0;
    aux[AUX_W-1] = 1'b0;
  end

  // ************************************************************
  // preset speed index: s1 s2 s3 s4 pattern to speed number
  // ************************************************************
  function automatic logic [SEL_W-1:0] spd_idx(input logic [SEL_W-1:0] s); // s[0] is s1
    case ({s[0], s[1], s[2], s[3]})
      4'b1000: spd_idx = 4'h1;
      4'b0100: spd_idx = 4'h2;
      4'b0010: spd_idx = 4'h3;
      4'b0001: spd_idx = 4'h4;
      4'b1100: spd_idx = 4'h5;
      4'b1010: spd_idx = 4'h6;
      4'b1001: spd_idx = 4'h7;
      4'b0110: spd_idx = 4'h8;
      4'b0101: spd_idx = 4'h9;
      4'b0011: spd_idx = 4'hA;
      4'b1110: spd_idx = 4'hB;
      4'b1101: spd_idx = 4'hC;
      4'b1011: spd_idx = 4'hD;
      4'b0111: spd_idx = 4'hE;
      4'b1111: spd_idx = 4'hF;
      default: spd_idx = 4'h0;
    endcase
  endfunction

  // ************************************************************
  // analog curve
  // ************************************************************
  ditd_analog_if ana ();
  assign ana.level   = use_current_input ? analog_current_input  : analog_voltage_input;
  assign ana.in_min  = use_current_input ? current_input_minimum : voltage_input_minimum;
  assign ana.in_max  = use_current_input ? current_input_maximum : voltage_input_maximum;
  assign ana.lo_freq = low_end_frequency;
  assign ana.lo_dir  = low_end_direction;
  assign ana.hi_freq = high_end_frequency;
  assign ana.hi_dir  = high_end_direction;
  assign ana.rev_opt = analog_reverse_option;

  ditd_analog_map u_map (
    .clock (clock),
    .rst_n (rst_n),
    .a     (ana.mapper)
  );

  // ************************************************************
  // up/down offset, step divider
  // ************************************************************
  logic [31:0]       div_d, div_q;
  logic              tick;
  logic [FREQ_W-1:0] updn_d, updn_q;
  logic              updn_act_d, updn_act_q;

  always_comb begin
    tick = (div_q >= 32'(UPDN_STEP - 1));
    div_d = tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
    updn_d = updn_q;
    updn_act_d = updn_act_q;
    if (!updn_act_q && (up ^ dn)) begin
      updn_d = primary_frequency_setting;
      updn_act_d = 1'b1;
    end else if (tick && up && !dn && updn_q < max_frequency) begin
      updn_d = updn_q + 16'h0001;
    end else if (tick && dn && !up && updn_q > min_frequency) begin
      updn_d = updn_q - 16'h0001;
    end
  end

  // volatile: reset always restarts from the primary setting
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_q      <= 32'h0000_0000;
      updn_q     <= FREQ_ZERO;
      updn_act_q <= 1'b0;
    end else begin
      div_q      <= div_d;
      updn_q     <= updn_d;
      updn_act_q <= updn_act_d;
    end
  end

  // ************************************************************
  // run, direction and frequency resolution
  // ************************************************************
  logic              run_d;
  logic              rev_d;
  logic              jog_d;
  logic              coast_d;
  logic              frst_d;
  logic [FREQ_W-1:0] freq_d;
  logic [SEL_W-1:0]  idx;
  logic [FREQ_W-1:0] base;
  logic              base_dir;

  always_comb begin
    idx = spd_idx(sel);
    base_dir = 1'b0;
    if (idx != 4'h0)
      base = preset_speeds[(idx - 4'h1) * FREQ_W +: FREQ_W];
    else if (updn_act_q)
      base = updn_q;
    else if (use_analog_reference) begin
      base = ana.freq;
      base_dir = ana.dir;
    end else
      base = primary_frequency_setting;
    run_d  = (forward_terminal | reverse_terminal | run_cmd) & ~stp;
    rev_d  = (reverse_terminal & ~forward_terminal) ^ base_dir ^ tog;
    jog_d  = 1'b0;
    freq_d = base;
    if (use_analog_reference && !ana.valid && idx == 4'h0 && !updn_act_q)
      run_d = 1'b0;
    if ((jog_any | jog_f | jog_r) && !stp) begin
      jog_d  = 1'b1;
      run_d  = 1'b1;
      freq_d = jog_frequency;
      rev_d  = (jog_r & ~jog_f) ^ tog;
    end
    if (!run_d)
      rev_d = 1'b0;
    coast_d = fn_on(terminal_function, terminal_in, FN_COAST);
    frst_d  = fn_on(terminal_function, terminal_in, FN_FAULTRST);
  end

  // output registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run_out          <= 1'b0;
      reverse_out      <= 1'b0;
      jog_out          <= 1'b0;
      target_frequency <= FREQ_ZERO;
      ramp_pair        <= '0;
      speed_index      <= '0;
      coast_stop       <= 1'b0;
      fault_reset      <= 1'b0;
      aux_enables      <= '0;
      analog_valid     <= 1'b0;
    end else begin
      run_out          <= run_d;
      reverse_out      <= rev_d;
      jog_out          <= jog_d;
      target_frequency <= freq_d;
      ramp_pair        <= rsel;                         // sel1 is bit 0
      speed_index      <= idx;
      coast_stop       <= coast_d;
      fault_reset      <= frst_d;
      aux_enables      <= aux;
      analog_valid     <= ana.valid;
    end
  end

  // ************************************************************
  // rule checks
  // ************************************************************
  // stop and idle terminals
  chk_stop_wins: assert property (@(posedge clock) disable iff (!rst_n)
    stp |=> !run_out) else $error("stop terminal did not stop");
  chk_jog_stop: assert property (@(posedge clock) disable iff (!rst_n)
    stp |=> !jog_out) else $error("stop terminal did not end jog");
  chk_idle_stop: assert property (@(posedge clock) disable iff (!rst_n)
    !(forward_terminal | reverse_terminal | run_cmd | jog_any | jog_f | jog_r) |=> !run_out)
    else $error("run with no command");

  // run sources and direction on a fixed reference
  chk_fwd_run: assert property (@(posedge clock) disable iff (!rst_n)
    forward_terminal && !stp && !use_analog_reference |=> run_out) else $error("forward terminal did not run");
  chk_run_cmd: assert property (@(posedge clock) disable iff (!rst_n)
    run_cmd && !stp && !use_analog_reference |=> run_out) else $error("run terminal did not run");
  chk_fwd_dir: assert property (@(posedge clock) disable iff (!rst_n)
    forward_terminal && !tog && !stp && !jog_d && !use_analog_reference |=> !reverse_out)
    else $error("forward terminal ran reverse");
  chk_rev_dir: assert property (@(posedge clock) disable iff (!rst_n)
    reverse_terminal && !forward_terminal && !tog && !stp && !jog_d && !use_analog_reference |=> reverse_out)
    else $error("reverse terminal ran forward");
  chk_toggle_dir: assert property (@(posedge clock) disable iff (!rst_n)
    forward_terminal && tog && !stp && !jog_d && !use_analog_reference |=> reverse_out)
    else $error("toggle did not invert direction");

  // jog direction
  chk_jog_fwd: assert property (@(posedge clock) disable iff (!rst_n)
    jog_f && !tog && !stp |=> jog_out && !reverse_out)
    else $error("jog forward ran reverse");
  chk_jog_rev: assert property (@(posedge clock) disable iff (!rst_n)
    jog_r && !jog_f && !tog && !stp |=> jog_out && reverse_out)
    else $error("jog reverse ran forward");

  // frequency selection
  chk_speed_zero: assert property (@(posedge clock) disable iff (!rst_n)
    sel == '0 |=> speed_index == 4'h0) else $error("preset chosen with no select");
  chk_preset_one: assert property (@(posedge clock) disable iff (!rst_n)
    sel == 4'h1 && !jog_d |=> target_frequency == $past(preset_speeds[FREQ_W-1:0]))
    else $error("first preset not applied");
  chk_jog_freq: assert property (@(posedge clock) disable iff (!rst_n)
    jog_d |=> jog_out && target_frequency == $past(jog_frequency)) else $error("jog freq wrong");
  chk_analog_gate: assert property (@(posedge clock) disable iff (!rst_n)
    use_analog_reference && !ana.valid && !updn_act_q && sel == '0 && !jog_d |=> !run_out)
    else $error("invalid analog reference ran the drive");

  // up/down ramp
  chk_updn_bound: assert property (@(posedge clock) disable iff (!rst_n)
    updn_act_q && up && !dn |=> updn_q <= max_frequency || $past(updn_q) > max_frequency)
    else $error("up ramp passed maximum");
  chk_updn_floor: assert property (@(posedge clock) disable iff (!rst_n)
    updn_act_q && dn && !up |=> updn_q >= min_frequency || $past(updn_q) < min_frequency)
    else $error("down ramp passed minimum");
  chk_updn_steady: assert property (@(posedge clock) disable iff (!rst_n)
    updn_act_q && !tick |=> updn_q == $past(updn_q)) else $error("ramp moved off the step tick");
  chk_updn_forget: assert property (@(posedge clock)
    !rst_n |=> !updn_act_q && updn_q == FREQ_ZERO) else $error("reset kept the ramp offset");

  // passed-out coast terminal function
  chk_coast_pass: assert property (@(posedge clock) disable iff (!rst_n)
    fn_on(terminal_function, terminal_in, FN_COAST) |=> coast_stop) else $error("coast not passed out");

endmodule
`default_nettype wire

// ---- tb/ditd_switch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// contact switches at the terminal block
// ****************************************
module ditd_switch_model
  import ditd_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic [NUM_TERMS-1:0] cmd,
  input  wire logic                 slow,
  output logic      [NUM_TERMS-1:0] terminal_in
);
  logic [NUM_TERMS-1:0] dly_q [3];

  // slow contacts follow the command four falling edges later, fast contacts one
  always @(negedge clock) begin
    dly_q[0] <= cmd;
    dly_q[1] <= dly_q[0];
    dly_q[2] <= dly_q[1];
    terminal_in <= slow ? dly_q[2] : cmd;
  end
endmodule
`default_nettype wire

// ---- tb/tb_drive_input_terminal_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_drive_input_terminal_decoder;
  import ditd_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic                        clock;
  logic                        rst_n;
  logic                        slow;
  logic [NUM_TERMS-1:0]        cmd;
  logic [NUM_TERMS-1:0]        term;
  logic [NUM_TERMS*CODE_W-1:0] fn;
  logic [ANA_W-1:0]            avin, vmin, vmax, acin, cmin, cmax;
  logic                        ucur, uana, lod, hid, revo;
  logic [FREQ_W-1:0]           lof, hif, prim, jogf, maxf, minf, tgt, t0;
  logic [15*FREQ_W-1:0]        pres;
  logic                        run_o, rev_o, jog_o, coast, frst, aval;
  logic [PAIR_W-1:0]           ramp;
  logic [SEL_W-1:0]            sidx;
  logic [AUX_W-1:0]            aux;
  logic [31:0]                 seed;
  int                          n_mismatch;
  int                          n_compared;
  localparam logic [3:0]  IDX [16] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h3, 4'h6, 4'h8, 4'hB,
                                       4'h4, 4'h7, 4'h9, 4'hC, 4'hA, 4'hD, 4'hE, 4'hF};
  localparam logic [11:0] OFF [5]  = '{12'h000, 12'h300, 12'h900, 12'hC00, 12'hD00};

  ditd_switch_model ditd_switch_model_i (.clock(clock), .cmd(cmd), .slow(slow), .terminal_in(term));

  ditd_top #(.UPDN_STEP(4)) ditd_top_i (
    .clock(clock), .rst_n(rst_n), .terminal_in(term), .terminal_function(fn),
    .analog_voltage_input(avin), .voltage_input_minimum(vmin), .voltage_input_maximum(vmax),
    .use_current_input(ucur), .analog_current_input(acin), .current_input_minimum(cmin),
    .current_input_maximum(cmax), .low_end_frequency(lof), .low_end_direction(lod),
    .high_end_frequency(hif), .high_end_direction(hid), .analog_reverse_option(revo),
    .use_analog_reference(uana), .primary_frequency_setting(prim), .jog_frequency(jogf),
    .max_frequency(maxf), .min_frequency(minf), .preset_speeds(pres), .run_out(run_o),
    .reverse_out(rev_o), .jog_out(jog_o), .target_frequency(tgt), .ramp_pair(ramp),
    .speed_index(sidx), .coast_stop(coast), .fault_reset(frst), .aux_enables(aux),
    .analog_valid(aval));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // signed curve point, bit 16 set for reverse
  function automatic logic [16:0] ana(input logic [11:0] l, mn, mx, input logic [15:0] lf, hf,
                                      input logic ld, hd, ro);
    int a, b, f;
    logic [11:0] x;
    x = (l > mx) ? mx : l;
    a = ld ? -int'(lf) : int'(lf);
    b = hd ? -int'(hf) : int'(hf);
    f = a + (b - a) * int'(x - mn) / int'(mx - mn);
    if (f < 0 && !ro) return 17'h00000;
    return {f < 0, (f < 0) ? 16'(-f) : 16'(f)};
  endfunction

  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic setfn(input int i, input logic [5:0] c);
    fn[6*i +: 6] = c;
  endtask

  task automatic clr();
    fn = '0;
    cmd = '0;
    wt(8);
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin : main
    logic [16:0] e;
    logic [11:0] mn;
    n_mismatch = 0;
    n_compared = 0;
    seed = 32'hD1E8028E;
    rst_n = 1'b0;
    {ucur, uana, lod, hid, revo, slow} = '0;
    {cmd, fn, avin, acin, lof, hif, minf} = '0;
    {vmin, vmax, cmin, cmax} = {12'h200, 12'hE00, 12'h100, 12'hD00};
    maxf = 16'hFFFF;
    seed = lfsr(seed);
    {prim, jogf} = {4'h1, seed[11:0], seed[31:16]};
    for (int i = 0; i < 15; i++) begin
      seed = lfsr(seed);
      pres[16*i +: 16] = seed[15:0];
    end
    wt(3);
    check("reset outputs", {run_o, rev_o, jog_o, tgt}, 19'h00000);
    rst_n = 1'b1;
    // forward and reverse terminals, contacts fast or slow
    setfn(0, FWD_FN_DEFAULT);
    setfn(1, REV_FN_DEFAULT);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      slow = seed[0];
      cmd[1:0] = k[1:0];
      wt(8);
      check("run", run_o, k != 0);
      check("reverse", rev_o, k == 2);
      if (k != 0) check("primary", tgt, prim);
    end
    // forward run with direction toggle
    setfn(1, FN_TOGGLE);
    for (int k = 0; k < 4; k++) begin
      cmd[1:0] = k[1:0];
      wt(8);
      check("toggle run", run_o, k[0]);
      if (k[0]) check("toggle dir", rev_o, k == 3);
    end
    // stop overrides, unused terminal is inert
    setfn(2, FN_STOP);
    setfn(3, FN_NONE);
    cmd = 8'h0D;
    wt(8);
    check("stop", run_o, 1'b0);
    cmd = 8'h09;
    wt(8);
    check("inert", {run_o, rev_o}, 2'b10);
    clr();
    // jog, jog forward, jog reverse
    for (int c = 1; c < 4; c++) begin
      setfn(5, c[5:0]);
      cmd = 8'h20;
      wt(8);
      check("jog", jog_o, 1'b1);
      check("jog freq", tgt, jogf);
      check("jog dir", rev_o, c == 3);
    end
    clr();
    setfn(6, FN_RUN);
    cmd = 8'h40;
    wt(8);
    check("run cmd", {run_o, rev_o}, 2'b10);
    clr();
    // all sixteen speed select patterns
    for (int i = 0; i < 4; i++) setfn(i, FN_SPD1 + i[5:0]);
    setfn(4, FN_FWD);
    for (int p = 0; p < 16; p++) begin
      cmd = {4'h1, p[3:0]};
      wt(8);
      check("speed index", sidx, IDX[p]);
      check("speed freq", tgt, (IDX[p] == 0) ? prim : pres[16*(IDX[p]-1) +: 16]);
    end
    clr();
    // ramp pair selects
    setfn(0, FN_RAMP1);
    setfn(1, FN_RAMP1 + 6'h01);
    for (int r = 0; r < 4; r++) begin
      cmd[1:0] = r[1:0];
      wt(8);
      check("ramp pair", ramp, r[1:0]);
    end
    clr();
    // coast, fault reset and passed-out enables
    for (int c = 17; c < 27; c++) begin
      setfn(7, c[5:0]);
      cmd = 8'h80;
      wt(8);
      check("coast", coast, c == 17);
      check("fault reset", frst, c == 18);
      check("aux", aux, (c > 18) ? 10'h001 << (c - 19) : 10'h000);
    end
    clr();
    // up and down ramping, limits, then reset forgets it
    maxf = prim + 16'h0064;
    minf = prim - 16'h0064;
    setfn(0, FN_FWD);
    setfn(1, FN_UP);
    setfn(2, FN_DOWN);
    cmd = 8'h03;
    wt(20);
    t0 = tgt;
    wt(40);
    check("up rate", tgt - t0, 16'h000A);
    wt(400);
    check("up limit", tgt, maxf);
    cmd = 8'h05;
    wt(20);
    t0 = tgt;
    wt(40);
    check("down rate", t0 - tgt, 16'h000A);
    wt(800);
    check("down limit", tgt, minf);
    cmd = 8'h01;
    rst_n = 1'b0;
    wt(3);
    rst_n = 1'b1;
    wt(8);
    check("restart freq", tgt, prim);
    {maxf, minf} = {16'hFFFF, 16'h0000};
    clr();
    // analog curves on both inputs, mirrored and clamped
    uana = 1'b1;
    setfn(0, FN_FWD);
    setfn(1, FN_REV);
    for (int c = 0; c < 2; c++) begin
      ucur = c[0];
      {lof, lod, hif, hid} = c ? {16'h2710, 1'b0, 16'h0000, 1'b0} : {16'h1388, 1'b1, 16'h1388, 1'b0};
      mn = c ? cmin : vmin;
      for (int j = 0; j < 20; j++) begin
        revo = j[0];
        cmd[1:0] = j[1] ? 2'b10 : 2'b01;
        seed = lfsr(seed);
        avin = c ? seed[11:0] : mn + OFF[j/4];
        acin = c ? mn + OFF[j/4] : seed[11:0];
        e = ana(mn + OFF[j/4], mn, c ? cmax : vmax, lof, hif, lod, hid, revo);
        wt(8);
        check("analog valid", aval, 1'b1);
        check("analog freq", tgt, e[15:0]);
        if (e[15:0] != 16'h0000) check("analog dir", rev_o, e[16] ^ j[1]);
      end
      t0 = tgt;
      avin = vmin - 12'h001;
      acin = cmin - 12'h001;
      wt(8);
      check("below min valid", aval, 1'b0);
      check("below min freq", tgt, t0);
      check("below min run", run_o, 1'b0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
